// ### src/smsp_map.vh
/*
 * Constants for the mode-0 serial slave port: frame width, FIFO shape and
 * the oscillator start-up wait.
 * Assumes the including file runs on a 25 MHz core clock.
 */
`ifndef SMSP_MAP_VH
`define SMSP_MAP_VH

// ****************************************************************
// Word and buffer shape, data-out reset level
// ****************************************************************
`define SMSP_WORD_BITS 8
`define SMSP_FIFO_DEPTH 32
`define SMSP_MISO_RESET 1'b0

// ****************************************************************
// Timing
// ****************************************************************
`define SMSP_CLK_HZ 25000000
`define SMSP_XTAL_START_US 2000
// Start-up wait in core cycles, 2000 us at 25 cycles per us, sized to the counter.
`define SMSP_XTAL_START_CYC 24'h00c350

`endif

// ### src/smsp_port.v
/*
 * Mode-0 serial slave port with a receive FIFO and a transmit word input,
 * plus the FIFO module that buffers received words.
 * Assumes the serial clock is well below a quarter of ref_clk_in and that
 * the pad logic resolves the data-out pin from its active-low enable.
 */
`timescale 1ns/1ps
`include "smsp_map.vh"

// ****************************************************************
// Receive FIFO
// ****************************************************************
module smsp_fifo #(
    parameter WIDTH = `SMSP_WORD_BITS,
    parameter DEPTH = `SMSP_FIFO_DEPTH,
    parameter AW = 5
) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;

    assign in_ready_out = (count != DEPTH[AW:0]);
    assign out_valid_out = (count != {(AW+1){1'b0}});
    assign out_data_out = mem[rd_ptr];
    assign do_wr = in_valid_in && in_ready_out;
    assign do_rd = out_valid_out && out_ready_in;

    always @(posedge ref_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1 && DEPTH != (1 << AW))
                    ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1 && DEPTH != (1 << AW))
                    ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ****************************************************************
// Serial slave port
// ****************************************************************
module smsp_port #(
    parameter WIDTH = `SMSP_WORD_BITS,
    parameter DEPTH = `SMSP_FIFO_DEPTH,
    parameter [23:0] START_CYC = `SMSP_XTAL_START_CYC
) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire enable_in,
    input wire spi_sclk_in,
    input wire spi_ss_n_in,
    input wire spi_mosi_in,
    output wire spi_miso_out,
    output wire spi_miso_oe_n_out,
    output wire ready_out,
    output wire rx_valid_out,
    input wire rx_ready_in,
    output wire [WIDTH-1:0] rx_data_out,
    input wire [WIDTH-1:0] tx_data_in,
    output wire tx_take_out,
    output wire overrun_out
);
    reg [2:0] sclk_sync;
    reg [1:0] ss_sync;
    reg [1:0] mosi_sync;
    reg [1:0] en_sync;
    reg [23:0] start_cnt;
    reg ready;
    reg [WIDTH-1:0] rx_shift;
    reg [WIDTH-1:0] tx_shift;
    reg [3:0] bit_cnt;
    reg miso;
    reg word_valid;
    reg [WIDTH-1:0] word;
    reg take;
    reg overrun;
    reg first;
    wire sel;
    wire rise;
    wire fall;
    wire fifo_ready;

    // Third stage only feeds the edge detector, never the first flop.
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sclk_sync <= 3'h0;
            ss_sync <= 2'h3;
            mosi_sync <= 2'h0;
            en_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], spi_sclk_in};
            ss_sync <= {ss_sync[0], spi_ss_n_in};
            mosi_sync <= {mosi_sync[0], spi_mosi_in};
            en_sync <= {en_sync[0], enable_in};
        end
    end

    // Enable comes from a host pin, so it is synchronised first; a glitch only restarts the wait.
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            start_cnt <= 24'h0;
            ready <= 1'b0;
        end else if (!en_sync[1]) begin
            start_cnt <= 24'h0;
            ready <= 1'b0;
        end else if (start_cnt >= START_CYC - 24'h1) begin
            ready <= 1'b1;
        end else begin
            start_cnt <= start_cnt + 24'h1;
        end
    end

    assign sel = ready && !ss_sync[1];
    assign rise = sclk_sync[1] && !sclk_sync[2];
    assign fall = !sclk_sync[1] && sclk_sync[2];

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_shift <= {WIDTH{1'b0}};
            tx_shift <= {WIDTH{1'b0}};
            bit_cnt <= 4'h0;
            miso <= `SMSP_MISO_RESET;
            word_valid <= 1'b0;
            word <= {WIDTH{1'b0}};
            take <= 1'b0;
            overrun <= 1'b0;
            first <= 1'b1;
        end else begin
            take <= 1'b0;
            if (word_valid && fifo_ready) begin
                word_valid <= 1'b0;
            end
            if (!sel) begin
                // Each select period starts a fresh word count.
                bit_cnt <= 4'h0;
                first <= 1'b1;
            end else begin
                if (first) begin
                    // Mode 0 needs the first bit out before the first rising edge.
                    tx_shift <= {tx_data_in[WIDTH-2:0], 1'b0};
                    miso <= tx_data_in[WIDTH-1];
                    take <= 1'b1;
                    first <= 1'b0;
                end else if (fall && bit_cnt != 4'h0) begin
                    miso <= tx_shift[WIDTH-1];
                    tx_shift <= {tx_shift[WIDTH-2:0], 1'b0};
                end else if (fall) begin
                    miso <= tx_data_in[WIDTH-1];
                    tx_shift <= {tx_data_in[WIDTH-2:0], 1'b0};
                    take <= 1'b1;
                end
                if (rise) begin
                    rx_shift <= {rx_shift[WIDTH-2:0], mosi_sync[1]};
                    if (bit_cnt == WIDTH[3:0] - 4'h1) begin
                        bit_cnt <= 4'h0;
                        word <= {rx_shift[WIDTH-2:0], mosi_sync[1]};
                        word_valid <= 1'b1;
                        // A full buffer lets the new word overwrite the held word rather than stalling a master-paced link.
                        if (word_valid && !fifo_ready) begin
                            overrun <= 1'b1;
                        end
                    end else begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
            end
        end
    end

    assign spi_miso_out = miso;
    assign spi_miso_oe_n_out = !sel;
    assign ready_out = ready;
    assign tx_take_out = take;
    assign overrun_out = overrun;

    smsp_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(word_valid),
        .in_ready_out(fifo_ready),
        .in_data_in(word),
        .out_valid_out(rx_valid_out),
        .out_ready_in(rx_ready_in),
        .out_data_out(rx_data_out)
    );
endmodule

// ### testbench/smsp_port_sva.sv
/* Pin-level checks of the serial slave port.
   Assumes a mode-0 master that frames words with select. */
`timescale 1ns/1ps
module smsp_port_sva #(parameter WIDTH = 8) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire enable_in,
    input wire spi_sclk_in,
    input wire spi_ss_n_in,
    input wire spi_miso_out,
    input wire spi_miso_oe_n_out,
    input wire ready_out,
    input wire rx_valid_out,
    input wire rx_ready_in,
    input wire [WIDTH-1:0] rx_data_out,
    input wire [WIDTH-1:0] tx_data_in,
    input wire tx_take_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_oe; spi_ss_n_in [*4] |-> spi_miso_oe_n_out; endproperty
    a_oe: assert property (p_oe) else $error("out driven off select");
    property p_sel; spi_ss_n_in [*4] |=> !$rose(rx_valid_out); endproperty
    a_sel: assert property (p_sel) else $error("word off select");
    property p_miso; $changed(spi_miso_out) && !spi_miso_oe_n_out |-> !$past(spi_sclk_in, 2);
    endproperty
    a_miso: assert property (p_miso) else $error("out moved off fall");
    property p_load; tx_take_out |-> ##[0:1] spi_miso_out == tx_data_in[WIDTH-1]; endproperty
    a_load: assert property (p_load) else $error("first bit wrong");
    property p_rdy; !ready_out |-> spi_miso_oe_n_out && !tx_take_out; endproperty
    a_rdy: assert property (p_rdy) else $error("active before ready");
    property p_en; $rose(ready_out) |-> $past(enable_in, 3); endproperty
    a_en: assert property (p_en) else $error("ready without enable");
    property p_hold; rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("word dropped");
    property p_word; $rose(rx_valid_out) |-> !$past(spi_ss_n_in, 4); endproperty
    a_word: assert property (p_word) else $error("word from nowhere");
    c_word: cover property ($rose(rx_valid_out));
    c_take: cover property (tx_take_out);
    c_stall: cover property (rx_valid_out && !rx_ready_in);
endmodule

// ### testbench/smsp_master.sv
/* Mode-0 master model for the serial port.
   Assumes the bench runs one frame at a time through xfer. */
`timescale 1ns/1ps
module smsp_master (
    output logic sclk_out,
    output logic ss_n_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic oe_n_in
);
    // A released line must not show the last bit, so it shows a moving level.
    wire logic line = oe_n_in ? ~mosi_out : miso_in;
    initial begin
        sclk_out = 1'b0;
        ss_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx, input int half, output logic [7:0] rx);
        ss_n_out = 1'b0;
        #200;
        for (int i = 7; i >= 0; i--) begin
            mosi_out = tx[i];
            #half sclk_out = 1'b1;
            rx[i] = line;
            #half sclk_out = 1'b0;
        end
        #half ss_n_out = 1'b1;
        mosi_out = ~mosi_out;
    endtask
    // Clocks meant for another slave on the shared bus; select stays high throughout.
    task automatic spin(input int half);
        for (int i = 0; i < 8; i++) begin
            #half sclk_out = 1'b1;
            #half sclk_out = 1'b0;
        end
    endtask
endmodule

// ### testbench/tb.sv
/* Top bench: queue model of received words, master model and checker bind.
   Assumes START_CYC cut to 10 core cycles. */
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, rdy_in = 1'b0, stall = 1'b0, ovr_exp = 1'b0;
    logic [7:0] tx = 8'h00;
    logic [31:0] rs = 32'h3d;
    wire sclk, ss_n, mosi, miso, oe_n, rdy, rxv, take, ovr;
    wire [7:0] rxd;
    int error_cnt = 0, cmp_count = 0;
    logic [7:0] q[$];
    initial forever #20 clk = ~clk;
    smsp_port #(.START_CYC(24'h00000a)) u_dut(.ref_clk_in(clk), .reset_n_in(rst_n),
        .enable_in(en), .spi_sclk_in(sclk), .spi_ss_n_in(ss_n), .spi_mosi_in(mosi),
        .spi_miso_out(miso), .spi_miso_oe_n_out(oe_n), .ready_out(rdy), .rx_valid_out(rxv),
        .rx_ready_in(rdy_in), .rx_data_out(rxd), .tx_data_in(tx), .tx_take_out(take),
        .overrun_out(ovr));
    smsp_master u_mst(.sclk_out(sclk), .ss_n_out(ss_n), .mosi_out(mosi), .miso_in(miso),
        .oe_n_in(oe_n));
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic results();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic frame(input int half, input logic live);
        logic [7:0] m, r;
        m = rnd();
        @(posedge clk) #1 tx = rnd();
        // Queued before the frame so the drain never runs ahead of the model.
        if (live && q.size() < 33) q.push_back(m);
        else if (live) begin
            // A word meeting a blocked stage replaces the one held there.
            ovr_exp = 1'b1;
            q[q.size() - 1] = m;
        end
        u_mst.xfer(m, half, r);
        if (live) chk(r, tx);
        repeat (6) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        if (rxv === 1'b1 && rdy_in === 1'b1) chk(rxd, q.size() > 0 ? q.pop_front() : 8'hxx);
        #1 rdy_in = !stall && rnd() > 8'h7f;
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        frame(160, 1'b0);
        chk({7'h00, rxv}, 8'h00);
        @(posedge clk) #1 en = 1'b1;
        repeat (5) @(posedge clk);
        #1 chk({7'h00, rdy}, 8'h00);
        repeat (8) @(posedge clk);
        #1 chk({7'h00, rdy}, 8'h01);
        u_mst.spin(160);
        repeat (4) @(posedge clk);
        #1 chk({7'h00, rxv}, 8'h00);
        for (int i = 0; i < 8; i++) frame(i[0] ? 400 : 160, 1'b1);
        repeat (20) @(posedge clk);
        stall = 1'b1;
        #1 chk({7'h00, ovr}, 8'h00);
        for (int i = 0; i < 34; i++) frame(160, 1'b1);
        chk({7'h00, ovr}, {7'h00, ovr_exp});
        stall = 1'b0;
        repeat (200) @(posedge clk);
        #1 chk({7'h00, rxv}, 8'(q.size()));
        results();
    end
    initial begin
        #2000000;
        error_cnt++;
        results();
    end
endmodule
bind smsp_port smsp_port_sva #(.WIDTH(WIDTH)) u_sva(.ref_clk_in, .reset_n_in, .enable_in,
    .spi_sclk_in, .spi_ss_n_in, .spi_miso_out, .spi_miso_oe_n_out, .ready_out,
    .rx_valid_out, .rx_ready_in, .rx_data_out, .tx_data_in, .tx_take_out);
